// ### common/cms_defines.vh
/*
 * Constants for the chip mode, security and low-power block:
 * register offsets, field positions, mode codes, power states.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef CMS_DEFINES_VH
`define CMS_DEFINES_VH

// register byte offsets (aligned 32-bit words)
`define CMS_MODE_OFFSET 4'h0
`define CMS_MISC_OFFSET 4'h4
`define CMS_STATUS_OFFSET 4'h8
`define CMS_ADDR_W 4

// mode register fields: [2]=high, [1]=mid, [0]=low strap
`define CMS_MODE_W 3
`define CMS_MODE_RESET 3'h0
// mode codes as high,mid,low
`define CMS_MODE_SPECIAL_SINGLE 3'h0
`define CMS_MODE_EMUL_NARROW 3'h1
`define CMS_MODE_SPECIAL_TEST 3'h2
`define CMS_MODE_EMUL_WIDE 3'h3
`define CMS_MODE_NORMAL_SINGLE 3'h4
`define CMS_MODE_NORMAL_NARROW 3'h5
`define CMS_MODE_PERIPHERAL 3'h6
`define CMS_MODE_NORMAL_WIDE 3'h7
`define CMS_MODE_NORMAL_BIT 2

// misc register fields
`define CMS_MISC_FLASH_VISIBLE_BIT 0
`define CMS_MISC_OSC_COLPITTS_BIT 1
`define CMS_MISC_PSEUDO_STOP_BIT 2
`define CMS_MISC_FLASH_VISIBLE_RESET 1'b1
`define CMS_MISC_PSEUDO_STOP_RESET 1'b0

// status register fields
`define CMS_STAT_SECURE_BIT 0
`define CMS_STAT_DEBUG_ACTIVE_BIT 1
`define CMS_STAT_DEBUG_BLOCKED_BIT 2
`define CMS_STAT_FLASH_DISABLED_BIT 3
`define CMS_STAT_ERASE_VERIFIED_BIT 4
`define CMS_STAT_POWER_LSB 8

// power states
`define CMS_PWR_W 2
`define CMS_PWR_RUN 2'h0
`define CMS_PWR_WAIT 2'h1
`define CMS_PWR_PSTOP 2'h2
`define CMS_PWR_STOP 2'h3

// bus responses
`define CMS_RESP_OKAY 2'h0
`define CMS_RESP_SLVERR 2'h2

`endif

// ### testbench/cms_board_host.sv
/* board straps and serial debug host in front of the config block.
   bench sets the strap code and one-cycle host requests. */
`timescale 1ns/1ps
`default_nettype none
module cms_board_host (
    input wire logic i_clock,
    input wire logic [4:0] i_code,
    input wire logic i_act_req,
    input wire logic i_mw_req,
    input wire logic [2:0] i_mw_data,
    output logic [4:0] o_straps,
    output logic o_debug_activate = 1'b0,
    output logic o_debug_mode_write = 1'b0,
    output logic [2:0] o_debug_mode_data = 3'h0
);
    // peripheral code would fight the bus, so the board straps single chip
    assign o_straps = (i_code[4:2] == 3'h6) ? {3'h4, i_code[1:0]} : i_code;
    always @(posedge i_clock) begin
        o_debug_activate <= i_act_req;
        o_debug_mode_write <= i_mw_req;
        // data meaningless outside a write: keep it moving
        o_debug_mode_data <= i_mw_req ? i_mw_data : ~o_debug_mode_data;
    end
endmodule
`default_nettype wire

// ### testbench/cms_chip_config_properties.sv
/* assertions on strap capture, security gating and power states.
   bound onto cms_chip_config; one clock, sync active-low reset. */
`timescale 1ns/1ps
`include "cms_defines.vh"
`default_nettype none
module cms_chip_config_properties (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_mode_strap_high,
    input wire logic i_mode_strap_mid,
    input wire logic i_mode_strap_low,
    input wire logic i_flash_visibility_strap,
    input wire logic i_security_bits_secure,
    input wire logic i_debug_activate,
    input wire logic i_wait_instruction,
    input wire logic i_stop_instruction,
    input wire logic [2:0] o_mode,
    input wire logic o_flash_mapped,
    input wire logic o_debug_active,
    input wire logic o_debug_blocked,
    input wire logic o_osc_run,
    input wire logic o_periph_run,
    input wire logic o_timer_watchdog_run,
    input wire logic o_cpu_halt,
    input wire logic [1:0] o_power_state
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);
    logic rst_q;
    wire logic [2:0] st;
    wire logic cap;
    assign st = {i_mode_strap_high, i_mode_strap_mid, i_mode_strap_low};
    // first edge with reset released is the capture edge
    assign cap = i_rst_n && !rst_q;
    always_ff @(posedge i_clock) rst_q <= i_rst_n;
    a_mode_capture: assert property (cap |=> o_mode == $past(st))
        else $error("mode not captured");
    a_flash_single: assert property (cap && !st[1] && !st[0] |=> o_flash_mapped)
        else $error("flash not forced visible");
    a_flash_strap: assert property (cap && st[0] && !i_security_bits_secure
        |=> o_flash_mapped == $past(i_flash_visibility_strap)) else $error("flash strap");
    a_flash_test: assert property (cap && st == 3'h2 |=> !o_flash_mapped)
        else $error("flash visible in test mode");
    a_secure_block: assert property (cap && i_security_bits_secure && st != 3'h0
        |=> o_debug_blocked && !o_debug_active) else $error("debug not blocked");
    a_secure_noflash: assert property (cap && i_security_bits_secure && (st[1] || st[0])
        |=> !o_flash_mapped) else $error("flash not disabled");
    a_debug_idle: assert property (cap && st != 3'h0 && !i_debug_activate
        |=> !o_debug_active) else $error("debug active early");
    a_wait_enter: assert property (o_power_state == `CMS_PWR_RUN && i_wait_instruction
        && !i_stop_instruction |=> o_power_state == `CMS_PWR_WAIT && o_cpu_halt
        && o_periph_run) else $error("wait entry");
    a_stop_static: assert property (o_power_state == `CMS_PWR_STOP
        |-> !o_osc_run && !o_periph_run && o_cpu_halt) else $error("stop not static");
    a_pstop_run: assert property (o_power_state == `CMS_PWR_PSTOP
        |-> o_osc_run && o_timer_watchdog_run && !o_periph_run) else $error("pseudo stop");
    c_pstop: cover property (o_power_state == `CMS_PWR_PSTOP);
    c_stop: cover property (o_power_state == `CMS_PWR_STOP);
    c_special: cover property (cap && st == 3'h0);
endmodule
bind cms_chip_config cms_chip_config_properties i_props (.i_clock, .i_rst_n,
    .i_mode_strap_high, .i_mode_strap_mid, .i_mode_strap_low, .i_flash_visibility_strap,
    .i_security_bits_secure, .i_debug_activate, .i_wait_instruction, .i_stop_instruction,
    .o_mode, .o_flash_mapped, .o_debug_active, .o_debug_blocked, .o_osc_run,
    .o_periph_run, .o_timer_watchdog_run, .o_cpu_halt, .o_power_state);
`default_nettype wire

// ### testbench/cms_chip_config_test.sv
/* self-checking bench: strap boots, mode filter, security, power states.
   drives cms_chip_config over AXI4-Lite and through cms_board_host. */
`timescale 1ns/1ps
`include "cms_defines.vh"
`default_nettype none
module cms_chip_config_test;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_security_bits_secure = 1'b0;
    logic i_flash_erased = 1'b0, i_erase_verify_pass = 1'b0, i_stop_instruction = 1'b0;
    logic i_wait_instruction = 1'b0, i_ext_interrupt = 1'b0, i_any_interrupt = 1'b0;
    logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, act = 1'b0, mw = 1'b0;
    logic [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hf;
    logic [31:0] i_s_axi_wdata = 32'h0, d;
    logic [4:0] code = 5'h0;
    logic [2:0] mwd = 3'h0, m;
    logic [1:0] r;
    int n_mismatch = 0, n_compared = 0;
    wire logic i_mode_strap_high, i_mode_strap_mid, i_mode_strap_low, i_debug_activate;
    wire logic i_flash_visibility_strap, i_oscillator_select_strap, i_debug_mode_write;
    wire logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    wire logic o_s_axi_rvalid, o_flash_mapped, o_osc_colpitts, o_debug_active;
    wire logic o_debug_blocked, o_security_unlock_allow, o_osc_run, o_clocks_run;
    wire logic o_timer_watchdog_run, o_periph_run, o_cpu_halt;
    wire logic [2:0] i_debug_mode_data, o_mode;
    wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_power_state;
    wire logic [31:0] o_s_axi_rdata;
    wire logic [4:0] straps;
    assign {i_mode_strap_high, i_mode_strap_mid, i_mode_strap_low} = straps[4:2];
    assign {i_flash_visibility_strap, i_oscillator_select_strap} = straps[1:0];
    cms_chip_config i_dut (.*);
    cms_board_host i_host (.i_clock, .i_code(code), .i_act_req(act), .i_mw_req(mw),
        .i_mw_data(mwd), .o_straps(straps), .o_debug_activate(i_debug_activate),
        .o_debug_mode_write(i_debug_mode_write), .o_debug_mode_data(i_debug_mode_data));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic fexp(input logic [2:0] md, input logic f);
        if (md == 3'h0 || md == 3'h4)
            return 1'b1;
        if (md == 3'h2)
            return 1'b0;
        return f;
    endfunction
    task automatic boot(input logic [4:0] c, input logic s);
        i_rst_n <= 1'b0;
        code <= c;
        i_security_bits_secure <= s;
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clock);
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= v;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
        do begin
            @(posedge i_clock);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (!o_s_axi_bvalid);
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic axi_rd(input logic [3:0] a);
        i_s_axi_araddr <= a;
        {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
        do begin
            @(posedge i_clock);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (!o_s_axi_rvalid);
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
        @(posedge i_clock);
    endtask
    // p = {activate, mode write, erase verified}
    task automatic host(input logic [2:0] p, input logic [2:0] dd);
        {act, mw, i_erase_verify_pass} <= p;
        mwd <= dd;
        @(posedge i_clock);
        {act, mw, i_erase_verify_pass} <= 3'h0;
        repeat (3) @(posedge i_clock);
    endtask
    // p = {stop, wait, any interrupt, external interrupt}
    task automatic pwr(input logic [3:0] p);
        {i_stop_instruction, i_wait_instruction, i_any_interrupt, i_ext_interrupt} <= p;
        @(posedge i_clock);
        {i_stop_instruction, i_wait_instruction, i_any_interrupt, i_ext_interrupt} <= 4'h0;
        repeat (2) @(posedge i_clock);
    endtask
    initial forever #5 i_clock = ~i_clock;
    initial begin
        repeat (5000) @(posedge i_clock);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        @(posedge i_clock);
        for (int i = 0; i < 16; i++) begin
            m = i[3:1];
            if (m != 3'h6) begin
                boot({m, i[0], ~i[0]}, 1'b0);
                axi_rd(`CMS_MISC_OFFSET);
                chk(o_mode, m);
                chk(d[1:0], {~i[0], fexp(m, i[0])});
                chk(o_flash_mapped, fexp(m, i[0]));
                chk(o_osc_colpitts, !i[0]);
                chk(o_debug_active, m == 3'h0);
            end
        end
        $display("test straps done");
        boot(5'h10, 1'b0);
        axi_wr(`CMS_MODE_OFFSET, 32'h2);
        chk(r, `CMS_RESP_OKAY);
        axi_rd(`CMS_MODE_OFFSET);
        chk(d, 32'h4);
        host(3'h4, 3'h0);
        chk(o_debug_active, 1'b1);
        host(3'h2, 3'h5);
        chk(o_mode, 3'h5);
        axi_wr(`CMS_MODE_OFFSET, 32'h7);
        chk(o_mode, 3'h5);
        boot(5'h0, 1'b0);
        axi_wr(`CMS_MODE_OFFSET, 32'h6);
        chk(o_mode, 3'h0);
        axi_wr(`CMS_MODE_OFFSET, 32'h7);
        chk(o_mode, 3'h7);
        axi_rd(4'hc);
        chk({r, d[29:0]}, {`CMS_RESP_SLVERR, 30'h0});
        axi_wr(4'hc, 32'h1);
        chk(r, `CMS_RESP_SLVERR);
        $display("test modes done");
        boot(5'h10, 1'b1);
        host(3'h4, 3'h0);
        chk({o_debug_blocked, o_debug_active, o_flash_mapped}, 3'h5);
        axi_rd(`CMS_STATUS_OFFSET);
        chk({d[2], d[0]}, 2'h3);
        boot(5'h1e, 1'b1);
        chk({o_debug_blocked, o_flash_mapped}, 2'h2);
        boot(5'h0, 1'b1);
        host(3'h1, 3'h0);
        chk({o_security_unlock_allow, o_debug_blocked}, 2'h1);
        i_flash_erased <= 1'b1;
        host(3'h1, 3'h0);
        chk({o_security_unlock_allow, o_debug_blocked}, 2'h2);
        host(3'h2, 3'h5);
        chk(o_mode, 3'h5);
        boot(5'h0, 1'b1);
        chk({o_security_unlock_allow, o_debug_blocked}, 2'h1);
        $display("test security done");
        boot(5'h10, 1'b0);
        axi_wr(`CMS_MISC_OFFSET, 32'h0);
        pwr(4'h8);
        chk({o_power_state, o_osc_run, o_clocks_run, o_periph_run}, 5'h18);
        pwr(4'h2);
        chk(o_power_state, `CMS_PWR_STOP);
        pwr(4'h1);
        chk(o_power_state, `CMS_PWR_RUN);
        axi_wr(`CMS_MISC_OFFSET, 32'h4);
        pwr(4'h8);
        chk({o_power_state, o_osc_run, o_timer_watchdog_run, o_periph_run}, 5'h16);
        pwr(4'h2);
        chk(o_power_state, `CMS_PWR_RUN);
        pwr(4'h4);
        chk({o_power_state, o_periph_run, o_cpu_halt}, 4'h7);
        pwr(4'h2);
        chk(o_power_state, `CMS_PWR_RUN);
        // bench never enables spare peripherals; run state keeps core, oscillator and peripherals going
        chk({o_periph_run, o_cpu_halt, o_osc_run}, 3'h5);
        $display("test power done");
        print_verdict();
    end
endmodule
`default_nettype wire

// ### verilog/cms_chip_config.v
/*
 * Chip configuration: strap capture at reset release, mode register with
 * restricted switching, flash visibility, security enforcement, debug
 * port gating and the run/wait/stop/pseudo-stop power sequencer, with an
 * AXI4-Lite register slave.
 * Assumes straps, security bits and debug host inputs synchronous to
 * i_clock; stop/wait requests are one-cycle pulses from the core.
 */
`timescale 1ns/1ps
`include "cms_defines.vh"
`default_nettype none

// Contract
// R1 - mode straps captured into mode bits at reset release, defining mode
// R2 - mode bits readable; only restricted mode changes accepted at run time
// R3 - flash-visibility strap captured into flash-visible bit at reset release
// R4 - flash mapped when flash-visible bit is 1, absent when 0
// R5 - straps 000: special single-chip, debug active, flash visible forced 1
// R6 - other modes: debug allowed but inactive until host activation command
// R7 - straps 100: normal single-chip, flash visible forced 1
// R8 - straps 010: special test wide, flash visible forced 0
// R9 - straps 001/011: emulation narrow/wide, flash visible from strap
// R10 - straps 101: normal expanded narrow, flash visible equals strap
// R11 - straps 111: normal expanded wide, flash visible equals strap
// R12 - board never straps 110 peripheral mode
// R13 - oscillator strap 1 selects Colpitts, 0 Pierce or external clock
// R14 - oscillator strap sampled at reset release, held until next reset
// R15 - secured state taken from non-volatile flash security bits
// R16 - secured normal single-chip: all debug-port operations blocked
// R17 - secured reset into expanded mode: flash disabled, debug blocked
// R18 - unsecuring requires the internal flash to be erased
// R19 - erase verified in special single-chip before security bits reprogrammed
// R20 - debug host may write mode bits to switch into expanded mode
// R21 - reset before reprogramming comes back secured
// R22 - full stop halts all clocks and oscillator; wake by reset or ext irq
// R23 - pseudo stop keeps oscillator, timer and watchdog; others off (o_clocks_run also stays 1 here)
// R24 - wait halts execution, buses static, peripherals active
// R25 - software leaves unused peripherals disabled in run mode (no per-peripheral enable here; o_periph_run is 1 in run)
module cms_chip_config (
    input wire i_clock,
    input wire i_rst_n,
    input wire i_mode_strap_high,
    input wire i_mode_strap_mid,
    input wire i_mode_strap_low,
    input wire i_flash_visibility_strap,
    input wire i_oscillator_select_strap,
    input wire i_security_bits_secure,
    input wire i_flash_erased,
    input wire i_erase_verify_pass,
    input wire i_debug_activate,
    input wire i_debug_mode_write,
    input wire [2:0] i_debug_mode_data,
    input wire i_stop_instruction,
    input wire i_wait_instruction,
    input wire i_ext_interrupt,
    input wire i_any_interrupt,
    input wire [3:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output wire o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output wire o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [3:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output wire o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    output wire [2:0] o_mode,
    output wire o_flash_mapped,
    output wire o_osc_colpitts,
    output wire o_debug_active,
    output wire o_debug_blocked,
    output wire o_security_unlock_allow,
    output wire o_osc_run,
    output wire o_clocks_run,
    output wire o_timer_watchdog_run,
    output wire o_periph_run,
    output wire o_cpu_halt,
    output wire [1:0] o_power_state
);

    reg released_reg;
    reg [2:0] mode_reg, mode_next;
    reg [2:0] reset_mode_reg;
    reg flash_visible_reg;
    reg osc_colpitts_reg;
    reg pseudo_stop_reg;
    reg secure_reg;
    reg erase_verified_reg;
    reg debug_active_reg;
    reg [1:0] power_reg, power_next;
    reg aw_held_reg, w_held_reg;
    reg [3:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg w_strb0_reg;

    wire [2:0] strap_mode = {i_mode_strap_high, i_mode_strap_mid, i_mode_strap_low};
    wire capture = ~released_reg;
    wire in_special_single = (mode_reg == `CMS_MODE_SPECIAL_SINGLE);
    wire reset_expanded = (reset_mode_reg != `CMS_MODE_SPECIAL_SINGLE) &&
                          (reset_mode_reg != `CMS_MODE_NORMAL_SINGLE);
    wire flash_disabled = secure_reg & reset_expanded;
    wire debug_blocked = secure_reg & ~(in_special_single & erase_verified_reg);

    // strap-derived flash visibility per mode
    reg flash_vis_strap;
    always @* begin
        case (strap_mode)
            `CMS_MODE_SPECIAL_SINGLE: flash_vis_strap = 1'b1; // R5
            `CMS_MODE_NORMAL_SINGLE: flash_vis_strap = 1'b1; // R7
            `CMS_MODE_SPECIAL_TEST: flash_vis_strap = 1'b0; // R8
            `CMS_MODE_EMUL_NARROW,
            `CMS_MODE_EMUL_WIDE: flash_vis_strap = i_flash_visibility_strap; // R9
            `CMS_MODE_NORMAL_NARROW: flash_vis_strap = i_flash_visibility_strap; // R10
            `CMS_MODE_NORMAL_WIDE: flash_vis_strap = i_flash_visibility_strap; // R11
            // peripheral straps are a board fault; force flash visible as in special single-chip
            default: flash_vis_strap = 1'b1; // R12
        endcase
    end

    // run-time mode switching filter
    function mode_write_ok;
        input [2:0] cur;
        input [2:0] want;
        begin
            if (want == `CMS_MODE_PERIPHERAL) begin
                mode_write_ok = 1'b0;
            end else if (!cur[`CMS_MODE_NORMAL_BIT]) begin
                mode_write_ok = 1'b1;
            end else begin
                // normal modes may only step from single-chip into expanded
                mode_write_ok = (cur == `CMS_MODE_NORMAL_SINGLE) &&
                                ((want == `CMS_MODE_NORMAL_NARROW) ||
                                 (want == `CMS_MODE_NORMAL_WIDE));
            end
        end
    endfunction

    // write channel handshake
    wire wr_fire = aw_held_reg & w_held_reg & ~o_s_axi_bvalid;
    assign o_s_axi_awready = ~aw_held_reg & ~o_s_axi_bvalid;
    assign o_s_axi_wready = ~w_held_reg & ~o_s_axi_bvalid;
    assign o_s_axi_arready = ~o_s_axi_rvalid;
    wire wr_mode = wr_fire & (aw_addr_reg == `CMS_MODE_OFFSET) & w_strb0_reg;
    wire wr_misc = wr_fire & (aw_addr_reg == `CMS_MISC_OFFSET) & w_strb0_reg;
    wire wr_mapped = (aw_addr_reg == `CMS_MODE_OFFSET) ||
                     (aw_addr_reg == `CMS_MISC_OFFSET) ||
                     (aw_addr_reg == `CMS_STATUS_OFFSET);

    always @* begin
        mode_next = mode_reg;
        if (capture) begin
            mode_next = strap_mode; // R1
        end else if (i_debug_mode_write && debug_active_reg && !debug_blocked &&
                     mode_write_ok(mode_reg, i_debug_mode_data)) begin
            mode_next = i_debug_mode_data; // R20
        end else if (wr_mode && mode_write_ok(mode_reg, w_data_reg[2:0])) begin
            mode_next = w_data_reg[2:0]; // R2
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            released_reg <= 1'b0;
            mode_reg <= `CMS_MODE_RESET;
            reset_mode_reg <= `CMS_MODE_RESET;
            flash_visible_reg <= `CMS_MISC_FLASH_VISIBLE_RESET;
            osc_colpitts_reg <= 1'b0;
            pseudo_stop_reg <= `CMS_MISC_PSEUDO_STOP_RESET;
            // assume secured until the flash bits are read at release
            secure_reg <= 1'b1;
            erase_verified_reg <= 1'b0;
            debug_active_reg <= 1'b0;
        end else begin
            released_reg <= 1'b1;
            mode_reg <= mode_next;
            if (capture) begin
                reset_mode_reg <= strap_mode; // R1
                flash_visible_reg <= flash_vis_strap; // R3
                osc_colpitts_reg <= i_oscillator_select_strap; // R14
                secure_reg <= i_security_bits_secure; // R15 R21
                debug_active_reg <= (strap_mode == `CMS_MODE_SPECIAL_SINGLE); // R5
            end else begin
                if (i_debug_activate) begin
                    debug_active_reg <= 1'b1; // R6
                end
                // verify program only runs out of a special single-chip reset
                if (i_erase_verify_pass && i_flash_erased &&
                    reset_mode_reg == `CMS_MODE_SPECIAL_SINGLE) begin
                    erase_verified_reg <= 1'b1; // R18 R19
                end
                if (wr_misc) begin
                    pseudo_stop_reg <= w_data_reg[`CMS_MISC_PSEUDO_STOP_BIT];
                end
            end
        end
    end

    // power sequencer
    always @* begin
        power_next = power_reg;
        case (power_reg)
            `CMS_PWR_RUN: begin
                if (i_stop_instruction) begin
                    power_next = pseudo_stop_reg ? `CMS_PWR_PSTOP : `CMS_PWR_STOP;
                end else if (i_wait_instruction) begin
                    power_next = `CMS_PWR_WAIT; // R24
                end
            end
            `CMS_PWR_WAIT: begin
                if (i_any_interrupt) begin
                    power_next = `CMS_PWR_RUN;
                end
            end
            `CMS_PWR_PSTOP: begin
                if (i_any_interrupt) begin
                    power_next = `CMS_PWR_RUN; // R23
                end
            end
            `CMS_PWR_STOP: begin
                // only an external source can wake a fully static chip
                if (i_ext_interrupt) begin
                    power_next = `CMS_PWR_RUN; // R22
                end
            end
            default: power_next = `CMS_PWR_RUN;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            power_reg <= `CMS_PWR_RUN;
        end else begin
            power_reg <= power_next;
        end
    end

    // register bus
    reg [31:0] rd_data;
    reg rd_ok;
    always @* begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        case (i_s_axi_araddr)
            `CMS_MODE_OFFSET: rd_data[2:0] = mode_reg; // R2
            `CMS_MISC_OFFSET: begin
                rd_data[`CMS_MISC_FLASH_VISIBLE_BIT] = flash_visible_reg;
                rd_data[`CMS_MISC_OSC_COLPITTS_BIT] = osc_colpitts_reg;
                rd_data[`CMS_MISC_PSEUDO_STOP_BIT] = pseudo_stop_reg;
            end
            `CMS_STATUS_OFFSET: begin
                rd_data[`CMS_STAT_SECURE_BIT] = secure_reg;
                rd_data[`CMS_STAT_DEBUG_ACTIVE_BIT] = o_debug_active;
                rd_data[`CMS_STAT_DEBUG_BLOCKED_BIT] = debug_blocked;
                rd_data[`CMS_STAT_FLASH_DISABLED_BIT] = flash_disabled;
                rd_data[`CMS_STAT_ERASE_VERIFIED_BIT] = erase_verified_reg;
                rd_data[`CMS_STAT_POWER_LSB +: 2] = power_reg;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0000_0000;
            w_strb0_reg <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `CMS_RESP_OKAY;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rresp <= `CMS_RESP_OKAY;
            o_s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {i_s_axi_awaddr[3:2], 2'b00};
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_s_axi_wdata;
                w_strb0_reg <= i_s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_mapped ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_data;
                o_s_axi_rresp <= rd_ok ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign o_mode = mode_reg;
    assign o_flash_mapped = flash_visible_reg & ~flash_disabled; // R4 R17
    assign o_osc_colpitts = osc_colpitts_reg; // R13
    assign o_debug_active = debug_active_reg & ~debug_blocked; // R6 R16 R17
    assign o_debug_blocked = debug_blocked; // R16 R17
    assign o_security_unlock_allow = secure_reg & erase_verified_reg; // R19
    assign o_osc_run = (power_reg != `CMS_PWR_STOP); // R22 R23
    assign o_clocks_run = (power_reg != `CMS_PWR_STOP); // R22
    assign o_timer_watchdog_run = (power_reg != `CMS_PWR_STOP); // R23
    assign o_periph_run = (power_reg == `CMS_PWR_RUN) ||
                          (power_reg == `CMS_PWR_WAIT); // R23 R24
    assign o_cpu_halt = (power_reg != `CMS_PWR_RUN); // R24
    assign o_power_state = power_reg;

endmodule

`default_nettype wire
